// *** hw/radio_cfg_pkg.sv ***
package radio_cfg_pkg;

  // Register offsets as seen by the serial register commands.
  localparam logic [4:0] OFF_CONFIG   = 5'h00;
  localparam logic [4:0] OFF_PIPE_EN  = 5'h02;
  localparam logic [4:0] OFF_AW       = 5'h03;
  localparam logic [4:0] OFF_RETR     = 5'h04;
  localparam logic [4:0] OFF_CHANNEL  = 5'h05;
  localparam logic [4:0] OFF_RADIO    = 5'h06;
  localparam logic [4:0] OFF_STATUS   = 5'h07;
  localparam int         NUM_REGS     = 8;
  localparam int         SNAP_W       = NUM_REGS * 8;

  // Serial command layout: top three bits select read or write.
  localparam logic [2:0] CMD_READ     = 3'h0;
  localparam logic [2:0] CMD_WRITE    = 3'h1;
  localparam logic [2:0] BIT_LAST     = 3'h7;

  // Field positions and reset values.
  localparam int         MASK_LSB     = 4;
  localparam int         RETR_DLY_LSB = 4;
  localparam int         ST_RX        = 6;
  localparam int         ST_TX        = 5;
  localparam int         ST_RT        = 4;
  localparam logic [2:0] MASK_RST     = 3'h0;
  localparam logic [5:0] PIPE_EN_RST  = 6'h03;
  localparam logic [1:0] AW_RST       = 2'h3;
  localparam logic [1:0] AW_ILLEGAL   = 2'h0;
  localparam logic [7:0] RETR_RST     = 8'h03;
  localparam logic [6:0] CHANNEL_RST  = 7'h02;
  localparam logic [4:0] RADIO_RST    = 5'h0F;
  localparam logic [2:0] PIPE_EMPTY   = 3'h7;

  // Retransmit delay step and the system clock rate.
  localparam int         RETRY_STEP_US = 250;
  localparam int         CLK_MHZ       = 50;
  localparam int         DELAY_W       = 18;

  function automatic logic [7:0] snap_byte(input logic [SNAP_W-1:0] snap,
                                           input logic [4:0] idx);
    snap_byte = (int'(idx) < NUM_REGS) ? snap[idx[2:0]*8 +: 8] : 8'h00;
  endfunction

endpackage

// *** hw/radio_config_status_regs.sv ***
`timescale 1ns/1ps
// Behaviour
// - Address width code resets to 3; 1,2,3 mean 3,4,5 bytes; 0 never stored.
// - Shorter address widths use only the low bytes of stored addresses.
// - Retransmit delay code gives (code+1) x 250 us wait; resets to zero.
// - Retransmit count resets to 3; zero disables retransmission; N allows N retries.
// - Seven-bit channel field resets to 2 and selects the operating channel.
// - Two-bit power level resets to 3 and applies only in transmit mode.
// - Status byte shifts out while each command byte shifts in.
// - Receive-ready flag sets on a new payload; cleared only by writing one.
// - Transmit-done flag sets on a sent packet; writing one clears it.
// - With auto acknowledge, transmit-done waits for the acknowledgement.
// - Retry-exhausted flag sets at the limit and suspends work until cleared.
// - Read-only pipe field resets to 7 and reports the head payload pipe.
// - Interrupt output goes low while any unmasked event flag is set.
// - Mask bits stop a flag reaching the interrupt; flags still record.
module radio_config_status_regs
  import radio_cfg_pkg::*;
#(
  parameter int RETRY_STEP_CYC = RETRY_STEP_US * CLK_MHZ
)(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               sck,
  input  wire logic               csn,
  input  wire logic               mosi,
  output logic                    misoOut,
  output logic                    misoEnN,
  input  wire logic               rxPayloadIn,
  input  wire logic [2:0]         rxHeadPipe,
  input  wire logic               txPacketDone,
  input  wire logic               ackReceived,
  input  wire logic               autoAckEn,
  input  wire logic               retryLimitHit,
  input  wire logic               txFifoFull,
  input  wire logic               txMode,
  output logic                    irqN,
  output logic                    commSuspend,
  output logic [5:0]              pipeEnableBits,
  output logic [1:0]              addrWidthCode,
  output logic [4:0]              addrByteMask,
  output logic [3:0]              retryDelayCode,
  output logic [DELAY_W-1:0]      retryDelayCount,
  output logic [3:0]              retryLimit,
  output logic                    retryEnable,
  output logic [6:0]              channelSelect,
  output logic                    lockForce,
  output logic                    airRateSel,
  output logic [1:0]              txPowerLevel,
  output logic                    txPowerActive,
  output logic                    rxGainBoost
);

  function automatic logic [4:0] width_mask(input logic [1:0] code);
    case (code)
      2'h1:    width_mask = 5'h07;
      2'h2:    width_mask = 5'h0F;
      default: width_mask = 5'h1F;
    endcase
  endfunction

  function automatic logic [DELAY_W-1:0] delay_cycles(input logic [3:0] code);
    delay_cycles = DELAY_W'((int'(code) + 1) * RETRY_STEP_CYC);
  endfunction

  spi_bank_if link ();

  spi_link u_link (
    .sck     (sck),
    .rst_n   (rst_n),
    .csn     (csn),
    .mosi    (mosi),
    .misoOut (misoOut),
    .misoEnN (misoEnN),
    .bus     (link.link)
  );

  // Crossing: three flops on the write toggle and on chip select.
  logic [2:0] togSync_reg;
  logic [2:0] csSync_reg;
  logic       frameIdle_reg;
  logic       togSeen_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      togSync_reg <= 3'h0;
      csSync_reg  <= 3'h7;
    end else begin
      togSync_reg <= {togSync_reg[1:0], link.wrToggle};
      csSync_reg  <= {csSync_reg[1:0], csn};
    end
  end

  wire togStable  = (togSync_reg[1] == togSync_reg[2]);
  wire csStable   = (csSync_reg[1] == csSync_reg[2]);
  wire wrEvt      = togStable && (togSync_reg[2] != togSeen_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frameIdle_reg <= 1'b1;
      togSeen_reg   <= 1'b0;
    end else begin
      if (csStable) begin
        frameIdle_reg <= csSync_reg[2];
      end
      if (togStable) begin
        togSeen_reg <= togSync_reg[2];
      end
    end
  end

  // Write decode.
  wire [7:0] wd       = link.wrData;
  wire       wrConfig = wrEvt && (link.wrAddr == OFF_CONFIG);
  wire       wrPipeEn = wrEvt && (link.wrAddr == OFF_PIPE_EN);
  wire       wrAw     = wrEvt && (link.wrAddr == OFF_AW) && (wd[1:0] != AW_ILLEGAL);
  wire       wrRetr   = wrEvt && (link.wrAddr == OFF_RETR);
  wire       wrChan   = wrEvt && (link.wrAddr == OFF_CHANNEL);
  wire       wrRadio  = wrEvt && (link.wrAddr == OFF_RADIO);
  wire       wrStatus = wrEvt && (link.wrAddr == OFF_STATUS);

  logic [2:0] mask_reg;
  logic [5:0] pipeEn_reg;
  logic [1:0] aw_reg;
  logic [7:0] retr_reg;
  logic [6:0] chan_reg;
  logic [4:0] radio_reg;

  // Only the defined bits are stored, so reserved bits read back as zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg   <= MASK_RST;
      pipeEn_reg <= PIPE_EN_RST;
      aw_reg     <= AW_RST;
      retr_reg   <= RETR_RST;
      chan_reg   <= CHANNEL_RST;
      radio_reg  <= RADIO_RST;
    end else begin
      if (wrConfig) mask_reg <= wd[MASK_LSB +: 3];
      if (wrPipeEn) pipeEn_reg <= wd[5:0];
      if (wrAw) aw_reg <= wd[1:0];
      if (wrRetr) retr_reg <= wd;
      if (wrChan) chan_reg <= wd[6:0];
      if (wrRadio) radio_reg <= wd[4:0];
    end
  end

  // Event flags: a set in the same cycle as a clear wins.
  wire rxClr   = wrStatus && wd[ST_RX];
  wire txClr   = wrStatus && wd[ST_TX];
  wire rtClr   = wrStatus && wd[ST_RT];
  wire txSet   = autoAckEn ? ackReceived : txPacketDone;

  logic       rxFlag_reg;
  logic       txFlag_reg;
  logic       rtFlag_reg;
  logic       rxFlag_next;
  logic       txFlag_next;
  logic       rtFlag_next;
  logic [2:0] pipe_reg;
  logic       txFull_reg;

  assign rxFlag_next = rxPayloadIn | (rxFlag_reg & ~rxClr);
  assign txFlag_next = txSet | (txFlag_reg & ~txClr);
  assign rtFlag_next = retryLimitHit | (rtFlag_reg & ~rtClr);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxFlag_reg <= 1'b0;
      txFlag_reg <= 1'b0;
      rtFlag_reg <= 1'b0;
      pipe_reg   <= PIPE_EMPTY;
      txFull_reg <= 1'b0;
    end else begin
      rxFlag_reg <= rxFlag_next;
      txFlag_reg <= txFlag_next;
      rtFlag_reg <= rtFlag_next;
      pipe_reg   <= rxHeadPipe;
      txFull_reg <= txFifoFull;
    end
  end

  wire [7:0] statusByte = {1'b0, rxFlag_reg, txFlag_reg, rtFlag_reg, pipe_reg, txFull_reg};

  // The snapshot only moves while no frame is open, so the link side sees a
  // stable word for the whole frame. Status is therefore the value at frame start.
  logic [SNAP_W-1:0] snap_reg;
  // Reset image of the snapshot, built from constants only.
  localparam logic [SNAP_W-1:0] SNAP_RST = {4'h0, PIPE_EMPTY, 1'b0,
                                            3'h0, RADIO_RST, 1'b0, CHANNEL_RST,
                                            RETR_RST, 6'h00, AW_RST,
                                            2'h0, PIPE_EN_RST, 8'h00,
                                            1'b0, MASK_RST, 4'h0};
  wire  [SNAP_W-1:0] snap_next = {statusByte,
                                  3'h0, radio_reg,
                                  1'b0, chan_reg,
                                  retr_reg,
                                  6'h00, aw_reg,
                                  2'h0, pipeEn_reg,
                                  8'h00,
                                  1'b0, mask_reg, 4'h0};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_reg <= SNAP_RST;
    end else if (frameIdle_reg) begin
      snap_reg <= snap_next;
    end
  end
  assign link.snapshot = snap_reg;

  // Outputs towards the radio engine.
  wire   rxIrq           = rxFlag_reg & ~mask_reg[2];
  wire   txIrq           = txFlag_reg & ~mask_reg[1];
  wire   rtIrq           = rtFlag_reg & ~mask_reg[0];
  assign irqN            = ~(rxIrq | txIrq | rtIrq);
  assign commSuspend     = rtFlag_reg;
  assign pipeEnableBits  = pipeEn_reg;
  assign addrWidthCode   = aw_reg;
  assign addrByteMask    = width_mask(aw_reg);
  assign retryDelayCode  = retr_reg[RETR_DLY_LSB +: 4];
  assign retryDelayCount = delay_cycles(retr_reg[RETR_DLY_LSB +: 4]);
  assign retryLimit      = retr_reg[3:0];
  assign retryEnable     = (retr_reg[3:0] != 4'h0);
  assign channelSelect   = chan_reg;
  assign lockForce       = radio_reg[4];
  assign airRateSel      = radio_reg[3];
  assign txPowerLevel    = radio_reg[2:1];
  assign txPowerActive   = txMode;
  assign rxGainBoost     = radio_reg[0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  aw_legal_a: assert property (addrWidthCode != AW_ILLEGAL)
    else $error("Address width code holds the illegal value.");

  aw_mask_a: assert property (addrWidthCode == 2'h1 |-> addrByteMask == 5'h07)
    else $error("Three byte width does not select three low bytes.");

  delay_calc_a: assert property (retryDelayCode == 4'hF |->
                                 retryDelayCount == DELAY_W'(16 * RETRY_STEP_CYC))
    else $error("Longest retransmit delay count is wrong.");

  retry_off_a: assert property (retryLimit == 4'h0 |-> !retryEnable)
    else $error("Retransmission enabled with a zero count.");

  rx_set_a: assert property (rxPayloadIn |=> rxFlag_reg)
    else $error("Receive-ready flag missed a new payload.");

  rx_sticky_a: assert property (rxFlag_reg && !rxClr |=> rxFlag_reg)
    else $error("Receive-ready flag fell without a clear.");

  tx_ack_a: assert property (autoAckEn && txPacketDone && !ackReceived && !txFlag_reg
                             |=> !txFlag_reg)
    else $error("Transmit-done set before the acknowledgement.");

  tx_set_a: assert property (!autoAckEn && txPacketDone |=> txFlag_reg)
    else $error("Transmit-done flag missed a sent packet.");

  retry_stop_a: assert property (retryLimitHit |=> commSuspend [*2])
    else $error("Retry limit did not suspend communication.");

  pipe_track_a: assert property (##1 pipe_reg == $past(rxHeadPipe))
    else $error("Pipe field does not follow the receive head.");

  full_track_a: assert property (txFifoFull |=> statusByte[0])
    else $error("Full bit does not follow the transmit FIFO.");

  irq_fire_a: assert property ($rose(rxFlag_reg) && !mask_reg[2] |-> !irqN)
    else $error("Unmasked receive event did not pull the interrupt low.");

  mask_hold_a: assert property (mask_reg == 3'h7 |-> irqN)
    else $error("Fully masked flags still drive the interrupt.");

  tx_sticky_a: assert property (txFlag_reg && !txClr |=> txFlag_reg)
    else $error("Transmit-done flag fell without a clear.");

  rt_sticky_a: assert property (rtFlag_reg && !rtClr |=> rtFlag_reg)
    else $error("Retry-exhausted flag fell without a clear.");

  rt_set_a: assert property (retryLimitHit |=> rtFlag_reg)
    else $error("Retry-exhausted flag missed the limit.");

  rx_clear_a: assert property (rxFlag_reg && rxClr && !rxPayloadIn |=> !rxFlag_reg)
    else $error("Receive-ready flag ignored its clear.");

  tx_clear_a: assert property (txFlag_reg && txClr && !txSet |=> !txFlag_reg)
    else $error("Transmit-done flag ignored its clear.");

  rt_clear_a: assert property (rtFlag_reg && rtClr && !retryLimitHit |=> !rtFlag_reg)
    else $error("Retry-exhausted flag ignored its clear.");

  ack_set_a: assert property (autoAckEn && ackReceived |=> txFlag_reg)
    else $error("Transmit-done flag missed the acknowledgement.");

  irq_idle_a: assert property (!rxFlag_reg && !txFlag_reg && !rtFlag_reg |-> irqN)
    else $error("Interrupt low with no flag set.");

  tx_irq_a: assert property (txFlag_reg && !mask_reg[1] |-> !irqN)
    else $error("Unmasked transmit-done flag did not pull the interrupt low.");

  rt_irq_a: assert property (rtFlag_reg && !mask_reg[0] |-> !irqN)
    else $error("Unmasked retry flag did not pull the interrupt low.");

  aw_four_a: assert property (addrWidthCode == 2'h2 |-> addrByteMask == 5'h0F)
    else $error("Four byte width does not select four low bytes.");

  aw_five_a: assert property (addrWidthCode == 2'h3 |-> addrByteMask == 5'h1F)
    else $error("Five byte width does not select all bytes.");

  aw_drop_a: assert property (wrEvt && (link.wrAddr == OFF_AW) && (wd[1:0] == AW_ILLEGAL)
                              |=> $stable(aw_reg))
    else $error("Illegal address width write was stored.");

  delay_min_a: assert property (retryDelayCode == 4'h0 |->
                                retryDelayCount == DELAY_W'(RETRY_STEP_CYC))
    else $error("Shortest retransmit delay count is wrong.");

  retry_on_a: assert property (retryLimit != 4'h0 |-> retryEnable)
    else $error("Retransmission disabled with a nonzero count.");

  snap_frozen_a: assert property (!frameIdle_reg |=> $stable(snap_reg))
    else $error("Register snapshot moved during an open frame.");

  full_clear_a: assert property (!txFifoFull |=> !statusByte[0])
    else $error("Full bit set with room in the transmit FIFO.");

  pipe_empty_a: assert property (rxHeadPipe == PIPE_EMPTY |=>
                                 statusByte[3:1] == PIPE_EMPTY)
    else $error("Pipe field does not report an empty receive FIFO.");

  chan_write_a: assert property (wrChan |=> {1'b0, channelSelect} == ($past(wd) & 8'h7F))
    else $error("Channel write not applied.");

  retr_write_a: assert property (wrRetr |=> {retryDelayCode, retryLimit} == $past(wd))
    else $error("Retransmit write not applied.");

  mask_write_a: assert property (wrConfig |=> {1'b0, mask_reg, 4'h0} == ($past(wd) & 8'h70))
    else $error("Mask write not applied.");

  radio_write_a: assert property (wrRadio |=> {3'h0, radio_reg} == ($past(wd) & 8'h1F))
    else $error("Radio setup write not applied.");

  wr_cover: cover property (wrEvt && wrStatus);
  irq_cover: cover property ($fell(irqN) ##[1:1000] $rose(irqN));
  full_cover: cover property (txFifoFull ##1 statusByte[0]);
  retry_cover: cover property (rtFlag_reg && rtClr);
  frame_cover: cover property ($fell(frameIdle_reg));

endmodule

// *** hw/spi_bank_if.sv ***
`timescale 1ns/1ps
interface spi_bank_if;
  import radio_cfg_pkg::*;
  logic              wrToggle;
  logic [4:0]        wrAddr;
  logic [7:0]        wrData;
  logic [SNAP_W-1:0] snapshot;
  modport link (output wrToggle, output wrAddr, output wrData, input snapshot);
  modport bank (input wrToggle, input wrAddr, input wrData, output snapshot);
endinterface

// *** hw/spi_link.sv ***
`timescale 1ns/1ps
module spi_link
  import radio_cfg_pkg::*;
(
  input  wire logic  sck,
  input  wire logic  rst_n,
  input  wire logic  csn,
  input  wire logic  mosi,
  output logic       misoOut,
  output logic       misoEnN,
  spi_bank_if.link   bus
);

  logic [2:0] bitCnt_reg;
  logic       firstByte_reg;
  logic       dataDone_reg;
  logic [7:0] cmd_reg;
  logic [6:0] shift_reg;
  logic       wrTog_reg;
  logic [4:0] wrAddr_reg;
  logic [7:0] wrData_reg;

  // Frame state is cleared by chip select itself, since the serial clock stops between frames.
  wire       frameRst  = csn | ~rst_n;
  wire [7:0] rxByte    = {shift_reg, mosi};
  wire       byteEnd   = (bitCnt_reg == BIT_LAST);
  wire       isWrite   = (cmd_reg[7:5] == CMD_WRITE);
  wire       isRead    = (cmd_reg[7:5] == CMD_READ);
  wire       wrCapture = byteEnd && !firstByte_reg && !dataDone_reg && isWrite;
  wire [7:0] statusOut = snap_byte(bus.snapshot, OFF_STATUS);
  wire [7:0] readOut   = (isRead && !dataDone_reg) ? snap_byte(bus.snapshot, cmd_reg[4:0])
                                                   : 8'h00;
  wire [7:0] outByte   = firstByte_reg ? statusOut : readOut;

  always_ff @(posedge sck or posedge frameRst) begin
    if (frameRst) begin
      bitCnt_reg    <= 3'h0;
      firstByte_reg <= 1'b1;
      dataDone_reg  <= 1'b0;
      cmd_reg       <= 8'h00;
      shift_reg     <= 7'h00;
    end else begin
      bitCnt_reg <= bitCnt_reg + 3'h1;
      shift_reg  <= rxByte[6:0];
      if (byteEnd) begin
        firstByte_reg <= 1'b0;
        dataDone_reg  <= !firstByte_reg;
        if (firstByte_reg) begin
          cmd_reg <= rxByte;
        end
      end
    end
  end

  // The write toggle lives across frames, so only the device reset clears it.
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      wrTog_reg  <= 1'b0;
      wrAddr_reg <= 5'h00;
      wrData_reg <= 8'h00;
    end else if (wrCapture) begin
      wrTog_reg  <= ~wrTog_reg;
      wrAddr_reg <= cmd_reg[4:0];
      wrData_reg <= rxByte;
    end
  end

  // Status leaves while the command byte enters, most significant bit first.
  assign misoOut      = outByte[BIT_LAST - bitCnt_reg];
  assign misoEnN      = csn;
  assign bus.wrToggle = wrTog_reg;
  assign bus.wrAddr   = wrAddr_reg;
  assign bus.wrData   = wrData_reg;

endmodule

// *** sim/radio_config_status_regs_tb.sv ***
`timescale 1ns/1ps
module radio_config_status_regs_tb;
  import radio_cfg_pkg::*;
  localparam int STEP = 4;
  logic               clk;
  logic               rst_n;
  wire                sck;
  wire                csn;
  wire                mosi;
  wire                misoLine;
  logic               misoOut;
  logic               misoEnN;
  logic [3:0]         ev;
  logic [2:0]         rxHeadPipe;
  logic               autoAckEn;
  logic               txFifoFull;
  logic               txMode;
  logic               irqN;
  logic               commSuspend;
  logic [5:0]         pipeEnableBits;
  logic [1:0]         addrWidthCode;
  logic [4:0]         addrByteMask;
  logic [3:0]         retryDelayCode;
  logic [DELAY_W-1:0] retryDelayCount;
  logic [3:0]         retryLimit;
  logic               retryEnable;
  logic [6:0]         channelSelect;
  logic               lockForce;
  logic               airRateSel;
  logic [1:0]         txPowerLevel;
  logic               txPowerActive;
  logic               rxGainBoost;
  logic [7:0]         lastSt;
  logic [7:0]         rdv;
  int                 errTotal;
  int                 compares;

  assign misoLine = (misoEnN === 1'b0) ? misoOut : 1'bz;

  radio_config_status_regs #(.RETRY_STEP_CYC(STEP)) i_dut (
    .clk, .rst_n, .sck, .csn, .mosi, .misoOut, .misoEnN,
    .rxPayloadIn(ev[0]),
    .rxHeadPipe,
    .txPacketDone(ev[1]),
    .ackReceived(ev[2]),
    .autoAckEn,
    .retryLimitHit(ev[3]),
    .txFifoFull, .txMode, .irqN, .commSuspend, .pipeEnableBits,
    .addrWidthCode, .addrByteMask, .retryDelayCode, .retryDelayCount,
    .retryLimit, .retryEnable, .channelSelect, .lockForce, .airRateSel,
    .txPowerLevel, .txPowerActive, .rxGainBoost
  );

  spi_host_model i_host (.sck, .csn, .mosi, .miso(misoLine));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chkPort(input string n, input logic [17:0] e, input logic [17:0] g);
    compares++;
    if (g !== e) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkRd(input string n, input logic [4:0] a, input logic [7:0] e);
    i_host.xfer({CMD_READ, a}, 8'h00, lastSt, rdv);
    compares++;
    if (rdv !== e) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, rdv);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    i_host.xfer({CMD_WRITE, a}, d, lastSt, rdv);
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    #1 ev[k] = 1'b1;
    @(posedge clk);
    #1 ev[k] = 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic printVerdict();
    $display("counts: compares %0d mismatches %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic testReset();
    chkRd("config", OFF_CONFIG, 8'h00);
    chkRd("pipe enable", OFF_PIPE_EN, 8'h03);
    chkRd("width", OFF_AW, 8'h03);
    chkRd("retransmit", OFF_RETR, 8'h03);
    chkRd("channel", OFF_CHANNEL, 8'h02);
    chkRd("radio", OFF_RADIO, 8'h0F);
    chkRd("status", OFF_STATUS, 8'h0E);
    chkPort("irq", 18'h1, 18'(irqN));
    chkPort("delay", 18'(STEP), 18'(retryDelayCount));
    chkPort("width", 18'h3, 18'(addrWidthCode));
    chkPort("pipe enable", 18'h03, 18'(pipeEnableBits));
    chkPort("retry fields", 18'h03, 18'({retryDelayCode, retryLimit}));
    chkPort("radio", 18'h0F, 18'({lockForce, airRateSel, txPowerLevel, rxGainBoost}));
    chkPort("miso enable", 18'h1, 18'(misoEnN));
    $display("test reset done");
  endtask

  task automatic testWidth();
    for (int c = 1; c <= 3; c++) begin
      wr(OFF_AW, 8'(c));
      chkPort("byte mask", 18'((1 << (c + 2)) - 1), 18'(addrByteMask));
      chkRd("width", OFF_AW, 8'(c));
      chkPort("width", 18'(c), 18'(addrWidthCode));
    end
    wr(OFF_AW, 8'h00);
    chkRd("width kept", OFF_AW, 8'h03);
    $display("test width done");
  endtask

  task automatic testRetry();
    wr(OFF_RETR, 8'hF0);
    chkPort("delay", 18'(16 * STEP), 18'(retryDelayCount));
    chkPort("delay code", 18'hF, 18'(retryDelayCode));
    chkPort("retry enable", 18'h0, 18'(retryEnable));
    wr(OFF_RETR, 8'h0F);
    chkPort("delay", 18'(STEP), 18'(retryDelayCount));
    chkPort("limit", 18'h1F, 18'({retryEnable, retryLimit}));
    $display("test retry done");
  endtask

  task automatic testRadio();
    wr(OFF_CHANNEL, 8'hFF);
    chkRd("channel", OFF_CHANNEL, 8'h7F);
    chkPort("channel", 18'h7F, 18'(channelSelect));
    wr(OFF_RADIO, 8'hF9);
    chkRd("radio", OFF_RADIO, 8'h19);
    chkPort("power", 18'h0, 18'(txPowerLevel));
    chkPort("radio", 18'h19, 18'({lockForce, airRateSel, txPowerLevel, rxGainBoost}));
    chkPort("power active", 18'h1, 18'(txPowerActive));
    @(posedge clk);
    #1 txMode = 1'b0;
    chkPort("power active", 18'h0, 18'(txPowerActive));
    @(posedge clk);
    #1 txMode = 1'b1;
    chkPort("lock", 18'h1, 18'(lockForce));
    wr(OFF_RADIO, 8'h0F);
    chkPort("lock", 18'h0, 18'(lockForce));
    wr(OFF_PIPE_EN, 8'h2A);
    chkRd("pipe enable", OFF_PIPE_EN, 8'h2A);
    chkPort("pipe enable", 18'h2A, 18'(pipeEnableBits));
    chkRd("unmapped", 5'h1F, 8'h00);
    $display("test radio done");
  endtask

  task automatic testEvents();
    pulse(0);
    chkPort("irq", 18'h0, 18'(irqN));
    wr(OFF_STATUS, 8'h20);
    chkPort("status shift", 18'h4E, 18'(lastSt));
    chkRd("status", OFF_STATUS, 8'h4E);
    wr(OFF_STATUS, 8'h40);
    chkRd("status", OFF_STATUS, 8'h0E);
    chkPort("irq", 18'h1, 18'(irqN));
    @(posedge clk);
    #1 autoAckEn = 1'b1;
    pulse(1);
    chkRd("status", OFF_STATUS, 8'h0E);
    pulse(2);
    chkRd("status", OFF_STATUS, 8'h2E);
    wr(OFF_STATUS, 8'h20);
    @(posedge clk);
    #1 autoAckEn = 1'b0;
    pulse(1);
    chkRd("status", OFF_STATUS, 8'h2E);
    wr(OFF_STATUS, 8'h20);
    chkRd("status", OFF_STATUS, 8'h0E);
    pulse(3);
    chkPort("suspend", 18'h1, 18'(commSuspend));
    chkRd("status", OFF_STATUS, 8'h1E);
    wr(OFF_STATUS, 8'h10);
    chkPort("suspend", 18'h0, 18'(commSuspend));
    $display("test events done");
  endtask

  task automatic testMasks();
    wr(OFF_CONFIG, 8'h70);
    chkRd("config", OFF_CONFIG, 8'h70);
    pulse(0);
    pulse(1);
    pulse(3);
    chkPort("irq masked", 18'h1, 18'(irqN));
    chkRd("status", OFF_STATUS, 8'h7E);
    wr(OFF_CONFIG, 8'h00);
    chkPort("irq", 18'h0, 18'(irqN));
    wr(OFF_STATUS, 8'h70);
    chkPort("irq", 18'h1, 18'(irqN));
    $display("test masks done");
  endtask

  task automatic testStatusBits();
    @(posedge clk);
    #1 rxHeadPipe = 3'h3;
    txFifoFull = 1'b1;
    chkRd("status", OFF_STATUS, 8'h07);
    @(posedge clk);
    #1 rxHeadPipe = 3'h7;
    txFifoFull = 1'b0;
    chkRd("status", OFF_STATUS, 8'h0E);
    $display("test status bits done");
  endtask

  initial begin
    errTotal = 0;
    compares = 0;
    rst_n = 1'b0;
    ev = 4'h0;
    rxHeadPipe = 3'h7;
    autoAckEn = 1'b0;
    txFifoFull = 1'b0;
    txMode = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge clk);
    testReset();
    testWidth();
    testRetry();
    testRadio();
    testEvents();
    testMasks();
    testStatusBits();
    printVerdict();
  end

  // The whole run needs roughly 120 us; a hang is cut well after that.
  initial begin
    #1000000;
    errTotal++;
    printVerdict();
  end
endmodule

// *** sim/spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model (
  output logic      sck,
  output logic      csn,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sck = 1'b0;
    csn = 1'b1;
    mosi = 1'b0;
  end

  // Mode 0 frame of one command byte and one data byte, MSB first.
  // The line is sampled just before each rising edge, so no race with the device's shift.
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
                      output logic [7:0] st, output logic [7:0] rd);
    logic [15:0] tx;
    logic [15:0] rx;
    tx = {cmd, dat};
    csn = 1'b0;
    #200;
    for (int i = 15; i >= 0; i--) begin
      mosi = tx[i];
      #62.5;
      rx[i] = miso;
      sck = 1'b1;
      #62.5;
      sck = 1'b0;
    end
    #100;
    csn = 1'b1;
    mosi = ~mosi;
    st = rx[15:8];
    rd = rx[7:0];
    #400;
  endtask
endmodule
